// ### rtl/wcso_map.svh
// Functional notes
// - Cycle-done rises when the hold interval of the weld sequence ends.
// - Cycle-start still present at hold end keeps cycle-done while it stays.
// - Cycle-start already released at hold end gives a 40 ms cycle-done pulse.
// - A nonzero pause interval keeps cycle-done for the whole pause.
// - A shown message or alarm keeps cycle-done until it is cleared.
// - Current-on rises with first current: pre-weld, weld or upslope.
// - Current-on spans all weld and slope intervals, drops when current ends.
// - Select lines are binary weighted from 1; their sum is the program number.
// - Initial-resistance mode flags out-of-limit resistance; energy mode adds time limits.
// - Final-resistance mode flags out-of-limit resistance; energy mode adds time limits.
// - Weld-fault stays set until cleared from the panel or the fault-reset input.
`ifndef WCSO_MAP_SVH
`define WCSO_MAP_SVH
// Register byte offsets
`define WCSO_CTRL_OFS     8'h00
`define WCSO_RES_MIN_OFS  8'h04
`define WCSO_RES_MAX_OFS  8'h08
`define WCSO_TIME_MIN_OFS 8'h0C
`define WCSO_TIME_MAX_OFS 8'h10
`define WCSO_PAUSE_OFS    8'h14
`define WCSO_STATUS_OFS   8'h18
`define WCSO_IRQ_STAT_OFS 8'h1C
`define WCSO_IRQ_MASK_OFS 8'h20
// Control fields
`define WCSO_CTRL_MODE_LSB 0
`define WCSO_CTRL_ENE_BIT  2
`define WCSO_CTRL_CLR_BIT  3
// Interrupt bits
`define WCSO_IRQ_DONE  0
`define WCSO_IRQ_FAULT 1
`define WCSO_IRQ_PROG  2
// Reset values
`define WCSO_RES_MIN_RST  16'h0000
`define WCSO_RES_MAX_RST  16'hFFFF
`define WCSO_TIME_MIN_RST 16'h0000
`define WCSO_TIME_MAX_RST 16'hFFFF
// Timing
`define WCSO_CLK_HZ    200000000
`define WCSO_MS_PER_S  1000
`define WCSO_DONE_MS   40
`define WCSO_MS_CYCLES (`WCSO_CLK_HZ / `WCSO_MS_PER_S)
`endif

// ### rtl/wcso_pkg.sv
package wcso_pkg;
  // Resistance check selection
  typedef enum logic [1:0] {
    WCSO_CHK_OFF   = 2'h0,
    WCSO_CHK_INIT  = 2'h1,
    WCSO_CHK_FINAL = 2'h2
  } wcso_chk_t;

  // Cycle-done sequencer states
  typedef enum logic [1:0] {
    WCSO_ST_IDLE = 2'b01,
    WCSO_ST_HOLD = 2'b10
  } wcso_state_t;

  // Phase flags from the weld sequencer
  typedef struct packed {
    logic hold_done;
    logic preweld;
    logic upslope;
    logic weld;
    logic downslope;
  } wcso_seq_t;

  // Measurement result of one weld
  typedef struct packed {
    logic        valid;
    logic [15:0] init_res;
    logic [15:0] final_res;
    logic [15:0] weld_time;
  } wcso_meas_t;
endpackage

// ### rtl/wcso_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module wcso_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // wcso_sync

// ### rtl/wcso_top.sv
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "wcso_map.svh"
module wcso_top import wcso_pkg::*; #(
  parameter int MS_CYCLES = `WCSO_MS_CYCLES,
  parameter int DONE_MS   = `WCSO_DONE_MS,
  parameter int NSEL      = 8
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire wcso_seq_t       seq,
  input  wire wcso_meas_t      meas,
  input  wire logic            msg_shown,
  input  wire logic            cycle_start,
  input  wire logic            fault_reset,
  input  wire logic [NSEL-1:0] program_select_line,
  output logic                 cycle_done,
  output logic                 current_on,
  output logic                 weld_fault,
  output logic [NSEL-1:0]      program_num,
  output logic                 irq
);
  // Binary weighted sum of the select lines
  function automatic logic [NSEL-1:0] prog_decode(input logic [NSEL-1:0] l);
    logic [NSEL-1:0] s;
    s = '0;
    for (int i = 0; i < NSEL; i++) begin
      if (l[i]) begin
        s = s | (NSEL'(1) << i);
      end
    end
    return s;
  endfunction

  // Limit comparison
  function automatic logic out_of(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  // Address match for one register
  function automatic logic hit_at(input logic [7:0] a,
                                  input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Synchronised pins
  logic [NSEL+1:0] pins_s;
  logic            start_s;
  logic            frst_s;
  logic [NSEL-1:0] sel_s;

  wcso_sync #(.W(NSEL + 2)) wcso_sync_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({cycle_start, fault_reset, program_select_line}),
    .q       (pins_s)
  );

  assign start_s = pins_s[NSEL+1];
  assign frst_s  = pins_s[NSEL];
  assign sel_s   = pins_s[NSEL-1:0];

  // Registers
  logic [2:0]  ctrl_q;
  logic [15:0] res_min_q;
  logic [15:0] res_max_q;
  logic [15:0] time_min_q;
  logic [15:0] time_max_q;
  logic [15:0] pause_q;
  logic [2:0]  ist_q;
  logic [2:0]  imask_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // Block state
  wcso_state_t     st_q;
  wcso_state_t     st_d;
  logic            done_q;
  logic            cur_q;
  logic            fault_q;
  logic [NSEL-1:0] prog_q;
  logic            irq_q;
  logic            start_d1_q;
  logic            frst_d1_q;
  logic            keep_start_q;
  logic [15:0]     pulse_q;
  logic [15:0]     pause_cnt_q;
  logic [31:0]     div_q;
  logic            ms_tick;

  // APB decode
  wire        acc      = psel & penable & ~pready_q;
  wire        wr_en    = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire        hit_ctrl = hit_at(paddr, `WCSO_CTRL_OFS);
  wire        hit_rmin = hit_at(paddr, `WCSO_RES_MIN_OFS);
  wire        hit_rmax = hit_at(paddr, `WCSO_RES_MAX_OFS);
  wire        hit_tmin = hit_at(paddr, `WCSO_TIME_MIN_OFS);
  wire        hit_tmax = hit_at(paddr, `WCSO_TIME_MAX_OFS);
  wire        hit_paus = hit_at(paddr, `WCSO_PAUSE_OFS);
  wire        hit_stat = hit_at(paddr, `WCSO_STATUS_OFS);
  wire        hit_ist  = hit_at(paddr, `WCSO_IRQ_STAT_OFS);
  wire        hit_imsk = hit_at(paddr, `WCSO_IRQ_MASK_OFS);
  wire        hit_any  = hit_ctrl | hit_rmin | hit_rmax | hit_tmin | hit_tmax |
                         hit_paus | hit_stat | hit_ist | hit_imsk;
  wire        panel_clr = wr_en & hit_ctrl & pwdata[`WCSO_CTRL_CLR_BIT];

  // Status word: program, state and output levels
  wire [31:0] status_word = {16'h0, 8'(prog_q), 4'h0, st_q == WCSO_ST_HOLD, fault_q, cur_q, done_q};

  // Read data select
  wire [31:0] rd_mux =
    hit_ctrl ? {29'h0, ctrl_q} :
    hit_rmin ? {16'h0, res_min_q} :
    hit_rmax ? {16'h0, res_max_q} :
    hit_tmin ? {16'h0, time_min_q} :
    hit_tmax ? {16'h0, time_max_q} :
    hit_paus ? {16'h0, pause_q} :
    hit_stat ? status_word :
    hit_ist  ? {29'h0, ist_q} :
    hit_imsk ? {29'h0, imask_q} : 32'h0;

  // Bus handshake, one wait state per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & ~hit_any;
      if (acc && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= 3'h0;
      res_min_q  <= `WCSO_RES_MIN_RST;
      res_max_q  <= `WCSO_RES_MAX_RST;
      time_min_q <= `WCSO_TIME_MIN_RST;
      time_max_q <= `WCSO_TIME_MAX_RST;
      pause_q    <= 16'h0;
      imask_q    <= 3'h0;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_q     <= pwdata[2:0];
      if (hit_rmin) res_min_q  <= pwdata[15:0];
      if (hit_rmax) res_max_q  <= pwdata[15:0];
      if (hit_tmin) time_min_q <= pwdata[15:0];
      if (hit_tmax) time_max_q <= pwdata[15:0];
      if (hit_paus) pause_q    <= pwdata[15:0];
      if (hit_imsk) imask_q    <= pwdata[2:0];
    end
  end

  // Millisecond enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 32'h0;
    end else if (div_q == 32'(MS_CYCLES - 1)) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end
  assign ms_tick = div_q == 32'(MS_CYCLES - 1);

  // Edges of synchronised pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d1_q <= 1'b0;
      frst_d1_q  <= 1'b0;
    end else begin
      start_d1_q <= start_s;
      frst_d1_q  <= frst_s;
    end
  end
  wire start_rise = start_s & ~start_d1_q;
  wire frst_rise  = frst_s & ~frst_d1_q;

  // Reasons that hold cycle-done
  wire start_hold = keep_start_q & start_s;
  wire pulse_run  = pulse_q != 16'h0;
  wire pause_run  = pause_cnt_q != 16'h0;
  wire keep_done  = start_hold | pulse_run | pause_run | msg_shown;

  // Cycle-done state transitions
  always_comb begin
    st_d = st_q;
    case (st_q)
      WCSO_ST_IDLE: begin
        if (seq.hold_done) st_d = WCSO_ST_HOLD;
      end
      WCSO_ST_HOLD: begin
        if (!seq.hold_done && !keep_done) st_d = WCSO_ST_IDLE;
      end
      default: st_d = WCSO_ST_IDLE;
    endcase
  end

  // Sequencer state and cycle-done output
  wire done_d = st_d == WCSO_ST_HOLD;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= WCSO_ST_IDLE;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      done_q <= done_d;
    end
  end

  // Start seen at hold end, kept while the pin stays high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_start_q <= 1'b0;
    end else if (seq.hold_done) begin
      keep_start_q <= start_s;
    end else if (!start_s) begin
      keep_start_q <= 1'b0;
    end
  end

  // Fixed pulse when start was already released, in ms ticks
  wire [15:0] pulse_load = start_s ? 16'h0 : 16'(DONE_MS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 16'h0;
    end else if (seq.hold_done) begin
      pulse_q <= pulse_load;
    end else if (ms_tick && pulse_run) begin
      pulse_q <= pulse_q - 16'h1;
    end
  end

  // Pause interval counted from hold end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_cnt_q <= 16'h0;
    end else if (seq.hold_done) begin
      pause_cnt_q <= pause_q;
    end else if (ms_tick && pause_run) begin
      pause_cnt_q <= pause_cnt_q - 16'h1;
    end
  end

  // Current-on follows any current-carrying phase
  wire cur_d = seq.preweld | seq.upslope | seq.weld | seq.downslope;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= 1'b0;
    end else begin
      cur_q <= cur_d;
    end
  end

  // Fault criteria for resistance checks
  wire [1:0] mode   = ctrl_q[`WCSO_CTRL_MODE_LSB +: 2];
  wire       ene    = ctrl_q[`WCSO_CTRL_ENE_BIT];
  wire       t_bad  = ene & out_of(meas.weld_time, time_min_q, time_max_q);
  wire       i_bad  = (mode == WCSO_CHK_INIT) &
                      (out_of(meas.init_res, res_min_q, res_max_q) | t_bad);
  wire       f_bad  = (mode == WCSO_CHK_FINAL) &
                      (out_of(meas.final_res, res_min_q, res_max_q) | t_bad);
  wire       f_set  = meas.valid & (i_bad | f_bad);
  wire       f_clr  = panel_clr | frst_rise;

  // Fault latch, a new fault beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (f_set) begin
      fault_q <= 1'b1;
    end else if (f_clr) begin
      fault_q <= 1'b0;
    end
  end

  // Program number sampled on cycle start
  wire [NSEL-1:0] prog_d = prog_decode(sel_s);
  wire            prog_chg = start_rise & (prog_d != prog_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_q <= '0;
    end else if (start_rise) begin
      prog_q <= prog_d;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  wire [2:0] ev;
  assign ev[`WCSO_IRQ_DONE]  = (st_q == WCSO_ST_IDLE) & (st_d == WCSO_ST_HOLD);
  assign ev[`WCSO_IRQ_FAULT] = f_set & ~fault_q;
  assign ev[`WCSO_IRQ_PROG]  = prog_chg;
  wire [2:0] w1c = (wr_en & hit_ist) ? pwdata[2:0] : 3'h0;
  wire [2:0] ist_d = ev | (ist_q & ~w1c); // Next status, set beats clear
  wire       irq_d = |(ist_d & imask_q);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ist
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ist_q[gi] <= 1'b0;
        end else if (ev[gi]) begin
          ist_q[gi] <= 1'b1;
        end else if (w1c[gi]) begin
          ist_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Outputs straight from flops
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign cycle_done  = done_q;
  assign current_on  = cur_q;
  assign weld_fault  = fault_q;
  assign program_num = prog_q;
  assign irq         = irq_q;
endmodule // wcso_top

// ### test/test_weld_cycle_status_outputs.sv
`timescale 1ns/1ps
`include "wcso_map.svh"
module test_weld_cycle_status_outputs import wcso_pkg::*;;
  localparam int MS = 10;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        msg_shown = 1'h0, fault_reset = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  wcso_seq_t   seq = '0;
  wcso_meas_t  meas = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, cycle_done, current_on, weld_fault, irq, cycle_start, err, mk;
  logic [7:0]  program_select_line, program_num;
  int          err_total = 0, checked = 0, tmo = 0, n;

  wcso_top #(.MS_CYCLES(MS)) wcso_top_inst (.*);
  wcso_auto wcso_auto_inst (.*);

  // Clock and hang guard
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    tmo++;
    if (tmo == 20000) begin
      err_total++;
      results();
    end
  end

  // Verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // Hold-end pulse, then cycles until done falls
  task automatic hold_end(output int c);
    seq.hold_done <= 1'h1;
    @(posedge pclk);
    seq.hold_done <= 1'h0;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (cycle_done === 1'h1 && c < 3000);
  endtask

  // One weld result under a check mode
  task automatic weld(input logic [3:0] m, input logic [15:0] r, input logic [15:0] t, input logic f);
    apb(1'h1, `WCSO_CTRL_OFS, {28'h0, m | 4'h8});
    chk(weld_fault, 1'h0);
    meas <= {1'h1, m[1] ? ~r : r, m[1] ? r : ~r, t};
    @(posedge pclk);
    meas.valid <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(weld_fault, f);
    chk(irq, f & mk);
    apb(1'h1, `WCSO_IRQ_STAT_OFS, 32'h2);
    chk(irq, 1'h0);
  endtask

  // Test sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, `WCSO_RES_MAX_OFS, 32'h0);
    chk(rd, 32'hFFFF);
    apb(1'h0, 8'h40, 32'h0);
    chk(err, 1'h1);
    $display("register test end");
    for (int i = 0; i < 9; i++) begin
      wcso_auto_inst.go(i < 8 ? 8'h1 << i : 8'h3F, 3);
      repeat (6) @(posedge pclk);
      chk(program_num, i < 8 ? 8'h1 << i : 8'h3F);
      wcso_auto_inst.stop();
    end
    apb(1'h0, `WCSO_STATUS_OFS, 32'h0);
    chk(rd, 32'h00003F00);
    $display("program test end");
    for (int i = 0; i < 5; i++) begin
      seq <= {1'h0, 4'h8 >> i};
      repeat (2) @(posedge pclk);
      chk(current_on, i < 4);
    end
    $display("current test end");
    hold_end(n);
    chk(n >= 39 * MS && n <= 40 * MS + 3, 1'h1);
    wcso_auto_inst.go(8'h5, 1);
    repeat (3) @(posedge pclk);
    fork
      hold_end(n);
      begin
        repeat (60 * MS) @(posedge pclk);
        wcso_auto_inst.stop();
      end
    join
    chk(n >= 60 * MS && n <= 60 * MS + 8, 1'h1);
    apb(1'h1, `WCSO_PAUSE_OFS, 32'h3C);
    hold_end(n);
    chk(n >= 59 * MS && n <= 60 * MS + 3, 1'h1);
    apb(1'h1, `WCSO_PAUSE_OFS, 32'h0);
    fork
      hold_end(n);
      begin
        msg_shown <= 1'h1;
        repeat (70 * MS) @(posedge pclk);
        msg_shown <= 1'h0;
      end
    join
    chk(n >= 70 * MS && n <= 70 * MS + 3, 1'h1);
    $display("done test end");
    apb(1'h1, `WCSO_RES_MIN_OFS, 32'hA);
    apb(1'h1, `WCSO_RES_MAX_OFS, 32'h14);
    apb(1'h1, `WCSO_TIME_MIN_OFS, 32'h5);
    apb(1'h1, `WCSO_TIME_MAX_OFS, 32'h64);
    apb(1'h0, `WCSO_IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h00000005);
    apb(1'h1, `WCSO_IRQ_STAT_OFS, 32'h7);
    apb(1'h1, `WCSO_IRQ_MASK_OFS, 32'h2);
    mk = 1'h1;
    weld(4'h1, 16'h9, 16'h32, 1'h1);
    weld(4'h1, 16'hA, 16'h65, 1'h0);
    weld(4'h1, 16'h15, 16'h32, 1'h1);
    weld(4'h2, 16'h15, 16'h32, 1'h1);
    weld(4'h2, 16'h14, 16'h32, 1'h0);
    weld(4'h6, 16'hF, 16'h65, 1'h1);
    weld(4'h5, 16'hF, 16'h64, 1'h0);
    weld(4'h0, 16'h0, 16'h0, 1'h0);
    apb(1'h1, `WCSO_IRQ_MASK_OFS, 32'h0);
    mk = 1'h0;
    weld(4'h5, 16'hF, 16'h4, 1'h1);
    repeat (20) @(posedge pclk);
    chk(weld_fault, 1'h1);
    fault_reset <= 1'h1;
    repeat (2) @(posedge pclk);
    fault_reset <= 1'h0;
    repeat (4) @(posedge pclk);
    chk(weld_fault, 1'h0);
    apb(1'h0, `WCSO_CTRL_OFS, 32'h0);
    chk(rd, 32'h00000005);
    $display("fault test end");
    results();
  end
endmodule // test_weld_cycle_status_outputs

bind wcso_top wcso_monitor #(.MS_CYCLES(MS_CYCLES), .DONE_MS(DONE_MS), .NSEL(NSEL)) wcso_monitor_inst (.*);

// ### test/wcso_auto.sv
`timescale 1ns/1ps
module wcso_auto (
  input  wire logic       pclk,
  output logic            cycle_start,
  output logic [7:0]      program_select_line
);
  // Idle lines
  initial begin
    cycle_start = 1'h0;
    program_select_line = 8'h0;
  end
  // Lines first, start after a setup delay
  task automatic go(input logic [7:0] p, input int setup);
    program_select_line <= p;
    repeat (setup) @(posedge pclk);
    cycle_start <= 1'h1;
    @(posedge pclk);
  endtask
  // Stale lines are not held after release
  task automatic stop();
    cycle_start <= 1'h0;
    @(posedge pclk);
    program_select_line <= ~program_select_line;
    @(posedge pclk);
  endtask
endmodule // wcso_auto

// ### test/wcso_monitor.sv
`timescale 1ns/1ps
module wcso_monitor import wcso_pkg::*; #(
  parameter int MS_CYCLES = 10,
  parameter int DONE_MS   = 40,
  parameter int NSEL      = 8
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire wcso_seq_t       seq,
  input wire logic            msg_shown,
  input wire logic            cycle_start,
  input wire logic            fault_reset,
  input wire logic [NSEL-1:0] program_select_line,
  input wire logic            cycle_done,
  input wire logic            current_on,
  input wire logic            weld_fault,
  input wire logic [NSEL-1:0] program_num
);
  logic [15:0] cnt_q;
  logic [4:0]  hist_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Length of the done level, recent fault-reset pin values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0;
      hist_q <= 5'h0;
    end else begin
      cnt_q  <= cycle_done ? cnt_q + 16'h1 : 16'h0;
      hist_q <= {hist_q[3:0], fault_reset};
    end
  end
  // Cycle-done reasons
  done_rise_a: assert property (seq.hold_done |=> cycle_done) else $error("no done");
  start_hold_a: assert property (cycle_done && cycle_start && $past(cycle_start, 3) |=> cycle_done)
    else $error("done drop");
  pulse_min_a: assert property ($fell(cycle_done) |-> cnt_q >= (DONE_MS - 1) * MS_CYCLES)
    else $error("short done");
  msg_keep_a: assert property (msg_shown && cycle_done |=> cycle_done) else $error("msg drop");
  // Current, program and fault
  cur_on_a: assert property (|seq[3:0] |=> current_on) else $error("no current");
  cur_off_a: assert property (seq[3:0] == 4'h0 |=> !current_on) else $error("stuck current");
  prog_dec_a: assert property ($rose(cycle_start) ##1 ($stable(program_select_line) && cycle_start)[*5]
    |-> program_num == program_select_line) else $error("bad program");
  fault_hold_a: assert property (weld_fault && !psel && !fault_reset && hist_q == 5'h0 |=> weld_fault)
    else $error("fault drop");
  // Main scenarios seen
  cover property ($fell(cycle_done));
  cover property ($rose(weld_fault));
  cover property ($rose(current_on));
endmodule // wcso_monitor
